// ### pkg/dbi_pkg.sv
// constants and types for the doubleword bit-field insert datapath
// ==================================================================
// Contract
// - result is target with bits top..bottom replaced by low source bits
// - low-word insert: top from bits 15..11, bottom from 10..6, no bias
// - straddle insert: bottom from bits 10..6, unbiased, always low word
// - straddle and high-word: bits 15..11 plus 32 give the top bit
// - high-word insert: bits 10..6 plus 32 give the bottom bit
// - straddle decoded when major opcode 011111 and function 000101
// - low-word insert covers fields below bit 32, 1 to 32 bits
// - straddle covers top 32..63, bottom 0..31, sizes 2 to 64
// - high-word insert covers fields within bits 32..63, 1 to 32 bits
// - straddle result is fully defined for every encoding
// - release below 2 raises reserved instruction; no other exception
package dbi_pkg;

   // ===============================================================
   // widths
   localparam int DATA_W = 64;
   localparam int POS_W  = 6;
   localparam int INSN_W = 32;
   localparam int REL_W  = 3;

   // ===============================================================
   // instruction field positions
   localparam int OPC_MSB  = 31;
   localparam int OPC_LSB  = 26;
   localparam int TOP_MSB  = 15;
   localparam int TOP_LSB  = 11;
   localparam int BOT_MSB  = 10;
   localparam int BOT_LSB  = 6;
   localparam int FUNC_MSB = 5;
   localparam int FUNC_LSB = 0;

   // ===============================================================
   // encodings
   localparam logic [5:0] EXTENDED_MAJOR_OPCODE = 6'h1F;
   localparam logic [5:0] FUNC_STRADDLE         = 6'h05;
   localparam logic [5:0] FUNC_LOW_WORD         = 6'h07;
   localparam logic [5:0] FUNC_HIGH_WORD        = 6'h06;

   // ===============================================================
   // bias, release level and reset values
   localparam logic [POS_W-1:0]  WORD_BIAS   = 6'h20;
   localparam logic [REL_W-1:0]  MIN_RELEASE = 3'h2;
   localparam logic [DATA_W-1:0] RESULT_RST  = 64'h0;

   // which insert variant an instruction word selects
   typedef enum logic [1:0] {
      DBI_NONE,
      DBI_LOW,
      DBI_STRADDLE,
      DBI_HIGH
   } dbi_kind_t;

endpackage

// ### pkg/dbi_field_if.sv
// carrier between the decode stage and the bit-field merge unit
`timescale 1ns/10ps
interface dbi_field_if;
   import dbi_pkg::*;

   logic [POS_W-1:0]  top_bit;
   logic [POS_W-1:0]  bottom_bit;
   logic [DATA_W-1:0] source_register;
   logic [DATA_W-1:0] target_register;
   logic [DATA_W-1:0] field_mask;
   logic [DATA_W-1:0] merged;

   // decode side hands over bounds and operands
   modport decode (
      output top_bit,
      output bottom_bit,
      output source_register,
      output target_register,
      input  field_mask,
      input  merged
   );

   // merge side returns mask and merged word
   modport merge (
      input  top_bit,
      input  bottom_bit,
      input  source_register,
      input  target_register,
      output field_mask,
      output merged
   );

endinterface

// ### hdl/dbi_merge.sv
// combinational bit-field merge of source low bits into target
`timescale 1ns/10ps
module dbi_merge
   import dbi_pkg::*;
(
   dbi_field_if.merge fld
);

   logic [DATA_W-1:0] shifted;

   // ===============================================================
   // field mask, one comparator pair per bit
   // bottom above top leaves the mask empty, so target passes through
   genvar i;
   generate
      for (i = 0; i < DATA_W; i++) begin : g_mask
         localparam logic [POS_W-1:0] IDX = POS_W'(i);
         assign fld.field_mask[i] = (IDX >= fld.bottom_bit) &&
                                    (IDX <= fld.top_bit);
      end
   endgenerate

   // ===============================================================
   // align source low bits to the field bottom and merge
   assign shifted = fld.source_register << fld.bottom_bit;
   assign fld.merged = (fld.target_register & ~fld.field_mask) |
                       (shifted & fld.field_mask);

endmodule

// ### hdl/dbi_top.sv
// doubleword bit-field insert execution unit: decode, merge, write-back
`timescale 1ns/10ps
module dbi_top
   import dbi_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              issue_valid,
   input  wire logic [INSN_W-1:0] instr,
   input  wire logic [DATA_W-1:0] source_register,
   input  wire logic [DATA_W-1:0] target_register,
   input  wire logic [REL_W-1:0]  arch_release,
   output logic                   result_valid,
   output logic [DATA_W-1:0]      result,
   output logic                   reserved_exc,
   output logic                   field_unpredictable
);

   // ===============================================================
   // instruction field extraction
   logic [5:0]       major_opcode;
   logic [5:0]       func_field;
   logic [4:0]       raw_top;
   logic [4:0]       raw_bottom;
   logic [POS_W-1:0] unbiased_top;
   logic [POS_W-1:0] unbiased_bottom;
   logic [POS_W-1:0] biased_top_bit;
   logic [POS_W-1:0] biased_bottom_bit;

   assign major_opcode = instr[OPC_MSB:OPC_LSB];
   assign func_field   = instr[FUNC_MSB:FUNC_LSB];
   assign raw_top      = instr[TOP_MSB:TOP_LSB];
   assign raw_bottom   = instr[BOT_MSB:BOT_LSB];

   // 5-bit fields widened to 6 bits, with and without the word bias
   assign unbiased_top      = {1'b0, raw_top};
   assign unbiased_bottom   = {1'b0, raw_bottom};
   assign biased_top_bit    = unbiased_top + WORD_BIAS;
   assign biased_bottom_bit = unbiased_bottom + WORD_BIAS;

   // ===============================================================
   // variant decode
   logic      is_extended;
   dbi_kind_t kind;

   assign is_extended = (major_opcode == EXTENDED_MAJOR_OPCODE);

   // straddle match is exact on both opcode fields
   assign kind = !is_extended                    ? DBI_NONE :
                 (func_field == FUNC_STRADDLE)   ? DBI_STRADDLE :
                 (func_field == FUNC_LOW_WORD)   ? DBI_LOW :
                 (func_field == FUNC_HIGH_WORD)  ? DBI_HIGH :
                                                   DBI_NONE;

   // ===============================================================
   // true field bounds per variant
   logic [POS_W-1:0] top_bit;
   logic [POS_W-1:0] bottom_bit;

   always_comb begin
      case (kind)
         DBI_LOW: begin
            top_bit    = unbiased_top;
            bottom_bit = unbiased_bottom;
         end
         DBI_STRADDLE: begin
            top_bit    = biased_top_bit;
            bottom_bit = unbiased_bottom;
         end
         DBI_HIGH: begin
            top_bit    = biased_top_bit;
            bottom_bit = biased_bottom_bit;
         end
         default: begin
            top_bit    = unbiased_top;
            bottom_bit = unbiased_bottom;
         end
      endcase
   end

   // ===============================================================
   // merge unit
   dbi_field_if fld ();

   assign fld.top_bit         = top_bit;
   assign fld.bottom_bit      = bottom_bit;
   assign fld.source_register = source_register;
   assign fld.target_register = target_register;

   dbi_merge u_dbi_merge (
      .fld (fld.merge)
   );

   // ===============================================================
   // write-back decisions
   logic is_insert;
   logic old_release;
   logic bad_order;
   logic next_result_valid;
   logic next_reserved_exc;
   logic next_unpredictable;

   assign is_insert   = issue_valid && (kind != DBI_NONE);
   assign old_release = (arch_release < MIN_RELEASE);
   // straddle bounds can never cross, so only low/high can flag
   assign bad_order   = (bottom_bit > top_bit) &&
                        (kind != DBI_STRADDLE);

   assign next_result_valid  = is_insert && !old_release;
   assign next_reserved_exc  = is_insert && old_release;
   // a crossed field still completes; the merge leaves target as is
   assign next_unpredictable = next_result_valid && bad_order;

   // ===============================================================
   // output registers, one cycle after the operands
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         result_valid        <= 1'b0;
         reserved_exc        <= 1'b0;
         field_unpredictable <= 1'b0;
      end else begin
         result_valid        <= next_result_valid;
         reserved_exc        <= next_reserved_exc;
         field_unpredictable <= next_unpredictable;
      end
   end

   // result holds its last value between inserts
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         result <= RESULT_RST;
      end else if (next_result_valid) begin
         result <= fld.merged;
      end
   end

   // ===============================================================
   // checking helpers, built apart from the merge unit
   logic [DATA_W-1:0] chk_mask;
   logic [POS_W-1:0]  chk_span;

   // mask from two shifts, so a slip in the comparators shows up
   assign chk_mask = ({DATA_W{1'b1}} << bottom_bit) &
                     ({DATA_W{1'b1}} >> (POS_W'(DATA_W - 1) - top_bit));
   assign chk_span = top_bit - bottom_bit;

   // ===============================================================
   // assertions

   a_keep_outside_field: assert property (
      @(posedge clk) disable iff (!nrst)
      next_result_valid && !bad_order |=>
         ((result & ~$past(chk_mask)) ==
          ($past(target_register) & ~$past(chk_mask)))
   ) else $error("target bits outside the field changed");

   a_field_from_source: assert property (
      @(posedge clk) disable iff (!nrst)
      next_result_valid && !bad_order |=>
         ((result & $past(chk_mask)) ==
          (($past(source_register) << $past(bottom_bit)) &
           $past(chk_mask)))
   ) else $error("field bits do not come from low source bits");

   a_field_edges_match: assert property (
      @(posedge clk) disable iff (!nrst)
      next_result_valid && !bad_order |=>
         (result[$past(bottom_bit)] == $past(source_register[0])) &&
         (result[$past(top_bit)] ==
          $past(source_register[chk_span]))
   ) else $error("field end bits misplaced");

   a_low_no_bias: assert property (
      @(posedge clk) disable iff (!nrst)
      issue_valid && kind == DBI_LOW |->
         top_bit == {1'b0, instr[TOP_MSB:TOP_LSB]} &&
         bottom_bit == {1'b0, instr[BOT_MSB:BOT_LSB]}
   ) else $error("low-word bounds not taken unbiased");

   a_straddle_bottom: assert property (
      @(posedge clk) disable iff (!nrst)
      issue_valid && kind == DBI_STRADDLE |->
         bottom_bit == {1'b0, instr[BOT_MSB:BOT_LSB]} &&
         !bottom_bit[POS_W-1]
   ) else $error("straddle bottom bit not in the low word");

   a_top_bias_added: assert property (
      @(posedge clk) disable iff (!nrst)
      issue_valid && (kind == DBI_STRADDLE || kind == DBI_HIGH) |->
         top_bit == {1'b1, instr[TOP_MSB:TOP_LSB]}
   ) else $error("top bit bias of 32 missing");

   a_high_bottom_bias: assert property (
      @(posedge clk) disable iff (!nrst)
      issue_valid && kind == DBI_HIGH |->
         bottom_bit == {1'b1, instr[BOT_MSB:BOT_LSB]}
   ) else $error("high-word bottom bit bias of 32 missing");

   a_straddle_decode: assert property (
      @(posedge clk) disable iff (!nrst)
      (instr[OPC_MSB:OPC_LSB] == 6'h1F) &&
      (instr[FUNC_MSB:FUNC_LSB] == 6'h05) |->
         kind == DBI_STRADDLE
   ) else $error("straddle encoding not decoded");

   a_low_range: assert property (
      @(posedge clk) disable iff (!nrst)
      issue_valid && kind == DBI_LOW && !bad_order |->
         top_bit < 6'h20 && bottom_bit < 6'h20 &&
         chk_span <= 6'h1F
   ) else $error("low-word field outside bits 0..31");

   a_straddle_range: assert property (
      @(posedge clk) disable iff (!nrst)
      issue_valid && kind == DBI_STRADDLE |->
         top_bit >= 6'h20 && bottom_bit < 6'h20 &&
         chk_span >= 6'h01
   ) else $error("straddle field range wrong");

   a_high_range: assert property (
      @(posedge clk) disable iff (!nrst)
      issue_valid && kind == DBI_HIGH && !bad_order |->
         top_bit >= 6'h20 && bottom_bit >= 6'h20
   ) else $error("high-word field outside bits 32..63");

   a_straddle_defined: assert property (
      @(posedge clk) disable iff (!nrst)
      issue_valid && kind == DBI_STRADDLE && !old_release |=>
         result_valid && !field_unpredictable
   ) else $error("straddle insert not fully defined");

   a_old_release_trap: assert property (
      @(posedge clk) disable iff (!nrst)
      is_insert && arch_release < 3'h2 |=>
         reserved_exc && !result_valid && $stable(result)
   ) else $error("old release insert did not trap");

   a_no_other_trap: assert property (
      @(posedge clk) disable iff (!nrst)
      reserved_exc |->
         $past(is_insert) && $past(arch_release) < 3'h2
   ) else $error("reserved exception without cause");

   a_crossed_completes: assert property (
      @(posedge clk) disable iff (!nrst)
      is_insert && !old_release && bad_order |=>
         result_valid && field_unpredictable && !reserved_exc
   ) else $error("crossed field insert did not complete");

   a_one_cycle_result: assert property (
      @(posedge clk) disable iff (!nrst)
      result_valid |->
         $past(issue_valid) && $past(kind) != DBI_NONE &&
         result == $past(fld.merged)
   ) else $error("result not one clock after operands");

   a_result_pulse: assert property (
      @(posedge clk) disable iff (!nrst)
      !issue_valid |=> !result_valid && !reserved_exc
   ) else $error("result without an issue");

   // ===============================================================
   // output group consistency, beyond the per-variant checks above

   a_exc_alone: assert property (
      @(posedge clk) disable iff (!nrst)
      reserved_exc |-> !result_valid && !field_unpredictable
   ) else $error("trap raised together with a result");

   a_result_holds: assert property (
      @(posedge clk) disable iff (!nrst)
      !result_valid |-> $stable(result)
   ) else $error("result moved without a write-back");

   a_unpred_cause: assert property (
      @(posedge clk) disable iff (!nrst)
      field_unpredictable |->
         result_valid && $past(bad_order) && $past(kind) != DBI_STRADDLE
   ) else $error("crossed-field flag without a crossed field");

   a_crossed_keeps: assert property (
      @(posedge clk) disable iff (!nrst)
      is_insert && !old_release && bad_order |=>
         result == $past(target_register)
   ) else $error("crossed field changed the target");

   a_straddle_ordered: assert property (
      @(posedge clk) disable iff (!nrst)
      kind == DBI_STRADDLE |-> bottom_bit < top_bit && !bad_order
   ) else $error("straddle bounds crossed");

   a_high_size: assert property (
      @(posedge clk) disable iff (!nrst)
      issue_valid && kind == DBI_HIGH && !bad_order |->
         chk_span <= 6'h1F
   ) else $error("high-word field wider than 32 bits");

   a_other_ignored: assert property (
      @(posedge clk) disable iff (!nrst)
      issue_valid && kind == DBI_NONE |=>
         !result_valid && !reserved_exc && $stable(result)
   ) else $error("non-insert instruction produced an answer");

endmodule

// ### sim/dbi_pipe_model.sv
// decode and register-file stage model feeding the insert unit
`timescale 1ns/10ps
module dbi_pipe_model
   import dbi_pkg::*;
(
   output logic              issue_valid,
   output logic [INSN_W-1:0] instr,
   output logic [DATA_W-1:0] source_register,
   output logic [DATA_W-1:0] target_register,
   output logic [REL_W-1:0]  arch_release
);
   // ==============================================================
   // drive helpers
   // quiet start so nothing is issued before reset releases
   initial begin
      issue_valid     = 1'b0;
      instr           = 32'h0;
      source_register = 64'h0;
      target_register = 64'h0;
      arch_release    = 3'h0;
   end

   // raw drive; caller passes noise payload while idle so stale
   // operands never look like a held value
   task automatic drive(input logic v, input logic [INSN_W-1:0] w,
                        input logic [DATA_W-1:0] s, g,
                        input logic [REL_W-1:0] r);
      issue_valid     = v;
      instr           = w;
      source_register = s;
      target_register = g;
      arch_release    = r;
   endtask

   // insert encoding: major op, register numbers, bounds, function
   task automatic drive_insert(input int k, input logic [4:0] t, b,
                               input logic [9:0] regs,
                               input logic [DATA_W-1:0] s, g,
                               input logic [REL_W-1:0] r);
      logic [5:0] fn;
      fn = (k == 0) ? FUNC_LOW_WORD :
           (k == 1) ? FUNC_STRADDLE : FUNC_HIGH_WORD;
      drive(1'b1, {EXTENDED_MAJOR_OPCODE, regs, t, b, fn}, s, g, r);
   endtask
endmodule

// ### sim/dbi_tb.sv
// self-checking bench for the doubleword bit-field insert unit
`timescale 1ns/10ps
module dbi_tb
   import dbi_pkg::*;
;
   typedef struct {
      int                cyc;
      logic              exc;
      logic              unp;
      logic [DATA_W-1:0] data;
   } dbi_note_t;

   logic              clk;
   logic              nrst;
   logic              issue_valid;
   logic [INSN_W-1:0] instr;
   logic [DATA_W-1:0] source_register;
   logic [DATA_W-1:0] target_register;
   logic [REL_W-1:0]  arch_release;
   logic              result_valid;
   logic [DATA_W-1:0] result;
   logic              reserved_exc;
   logic              field_unpredictable;
   dbi_note_t         notes[$];
   logic [DATA_W-1:0] last_res;
   logic              mon_en;
   int                cyc;
   int                num_errors;
   int                total_checks;
   integer            seed;

   // ==============================================================
   // design and far-side model
   dbi_top u_dbi_top (
      .clk                 (clk),
      .nrst                (nrst),
      .issue_valid         (issue_valid),
      .instr               (instr),
      .source_register     (source_register),
      .target_register     (target_register),
      .arch_release        (arch_release),
      .result_valid        (result_valid),
      .result              (result),
      .reserved_exc        (reserved_exc),
      .field_unpredictable (field_unpredictable)
   );

   dbi_pipe_model u_dbi_pipe_model (
      .issue_valid     (issue_valid),
      .instr           (instr),
      .source_register (source_register),
      .target_register (target_register),
      .arch_release    (arch_release)
   );

   // ==============================================================
   // clock, cycle count, checking helpers
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   task automatic chk(input logic [DATA_W-1:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      if (num_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ==============================================================
   // stimulus tasks; expectation worked out bit by bit
   task automatic ins(input int k, input logic [4:0] t, b,
                      input logic [DATA_W-1:0] s, g,
                      input logic [REL_W-1:0] r);
      dbi_note_t  n;
      logic [5:0] top;
      logic [5:0] bot;
      top = {1'b0, t} + ((k != 0) ? WORD_BIAS : 6'h00);
      bot = {1'b0, b} + ((k == 2) ? WORD_BIAS : 6'h00);
      n.exc  = (r < MIN_RELEASE);
      n.unp  = !n.exc && (bot > top);
      n.data = g;
      if (!n.unp)
         for (int i = 0; i < DATA_W; i++)
            if (i >= int'(bot) && i <= int'(top))
               n.data[i] = s[i - int'(bot)];
      @(negedge clk);
      n.cyc = cyc;
      notes.push_back(n);
      u_dbi_pipe_model.drive_insert(k, t, b, 10'($random(seed)), s, g, r);
   endtask

   // idle or non-insert cycle with noise on every payload line
   task automatic idle(input logic v, input logic [INSN_W-1:0] w);
      @(negedge clk);
      u_dbi_pipe_model.drive(v, w, {$random(seed), $random(seed)},
                             {$random(seed), $random(seed)},
                             3'($random(seed)));
   endtask

   task automatic do_reset();
      idle(1'b0, 32'h0);
      mon_en = 1'b0;
      nrst   = 1'b0;
      repeat (5) @(negedge clk);
      chk(64'({result_valid, reserved_exc, field_unpredictable}),
          64'h0);
      chk(result, RESULT_RST);
      notes.delete();
      last_res = 64'h0;
      nrst     = 1'b1;
      mon_en   = 1'b1;
   endtask

   function automatic logic [DATA_W-1:0] rnd64();
      return {$random(seed), $random(seed)};
   endfunction

   // ==============================================================
   // monitor: oldest note against each answer, hold check otherwise
   always @(negedge clk) begin
      dbi_note_t n;
      if (mon_en === 1'b1) begin
         if (result_valid !== 1'b0 || reserved_exc !== 1'b0) begin
            if (notes.size() == 0) begin
               chk(64'h1, 64'h0);
            end else begin
               n = notes.pop_front();
               chk(64'(cyc - n.cyc), 64'h1);
               chk({result_valid, reserved_exc},
                   n.exc ? 2'b01 : 2'b10);
               chk(64'(field_unpredictable), 64'(n.unp));
               if (!n.exc)
                  last_res = n.data;
               chk(result, last_res);
            end
         end else begin
            chk(64'(field_unpredictable), 64'h0);
            chk(result, last_res);
         end
      end
   end

   // ==============================================================
   // main sequence
   initial begin
      seed         = 32'h11CA7D39;
      nrst         = 1'b0;
      mon_en       = 1'b0;
      cyc          = 0;
      num_errors   = 0;
      total_checks = 0;
      last_res     = 64'h0;
      do_reset();
      // field bounds at the corners of each variant, back to back
      ins(0, 5'h1F, 5'h00, rnd64(), rnd64(), 3'h2);
      ins(0, 5'h00, 5'h00, rnd64(), rnd64(), 3'h2);
      ins(1, 5'h1F, 5'h00, rnd64(), rnd64(), 3'h3);
      ins(1, 5'h00, 5'h1F, rnd64(), rnd64(), 3'h3);
      ins(2, 5'h1F, 5'h00, rnd64(), rnd64(), 3'h7);
      ins(2, 5'h00, 5'h00, rnd64(), rnd64(), 3'h7);
      ins(2, 5'h1F, 5'h1F, rnd64(), rnd64(), 3'h7);
      ins(0, 5'h03, 5'h09, rnd64(), rnd64(), 3'h2);
      // every release level against every variant
      for (int r = 0; r < 8; r++)
         for (int k = 0; k < 3; k++)
            ins(k, 5'h0A, 5'h03, rnd64(), rnd64(), 3'(r));
      // look-alikes: wrong major op, and an extract function code
      idle(1'b1, {6'h1E, 20'h12345, FUNC_STRADDLE});
      idle(1'b1, {EXTENDED_MAJOR_OPCODE, 20'h12345, 6'h03});
      idle(1'b0, {EXTENDED_MAJOR_OPCODE, 20'h12345, FUNC_STRADDLE});
      // random mix; crossed bounds appear on their own
      for (int j = 0; j < 400; j++) begin
         ins(int'($unsigned($random(seed)) % 3), 5'($random(seed)),
             5'($random(seed)), rnd64(), rnd64(),
             3'(2 + $unsigned($random(seed)) % 6));
         if ($random(seed) & 1)
            idle(1'b0, $random(seed));
      end
      // reset in mid-run, then traffic must resume cleanly
      do_reset();
      ins(1, 5'h05, 5'h1E, rnd64(), rnd64(), 3'h2);
      repeat (3) idle(1'b0, 32'h0);
      chk(64'(notes.size()), 64'h0);
      end_sim();
   end

   // ==============================================================
   // watchdog: run needs about 650 cycles
   initial begin
      #200000;
      num_errors++;
      end_sim();
   end
endmodule
